// ==== design/asp_port.sv ====
// Synchronous serial audio port with fractional clock divider, transmit
// and receive queues and a shared data window.
// Assumes the data window strobes come from core_clk logic and that the
// link pins are asynchronous; bit clock is drive on fall, sample on rise.
//
// How it works
// RULE_01: Fabric side and serial side kept apart.
// RULE_02: Internal clock from crystal or PLL reference.
// RULE_03: Frame direction must match bit clock direction.
// RULE_04: First external falling edge may be lost.
// RULE_05: Divider averages source times M over N.
// RULE_06: Divider has enable, update, M, N fields.
// RULE_07: Bypass passes reference clock undivided; here each reference strobe is one edge, so the bit clock is half the reference.
// RULE_08: Divider jitter bounded to one reference period.
// RULE_09: Bit rate capped at 12.5 Mbps.
// RULE_10: Sample length programmable 4 to 32.
// RULE_11: Separate 16 by 32 transmit, receive queues.
// RULE_12: Up to eight slots, per-slot enables.
// RULE_13: Software restarts port after changing configuration.
// RULE_14: Window accesses are 32-bit, one entry.
// RULE_15: Transmit ignores bits above sample size.
// RULE_16: Receive zero-fills bits above sample size.
// RULE_17: DMA bursts sized per sample, one entry.
// RULE_18: DMA width at least sample size.
// RULE_19: Threshold crossing raises service request.
// RULE_20: One address: read pops, write pushes.
// RULE_21: Transmit and receive paths run together.
// RULE_22: Serial data most significant bit first.
// RULE_23: Master clock toggles only during transfers.
// RULE_24: M and N change only on update.
// RULE_25: Flag receive overrun and transmit underrun.
`timescale 1ns/10ps
module asp_port #(
	parameter int DEPTH = asp_pkg::DEPTH,
	parameter int SLOTS = asp_pkg::SLOTS
) (
	input  wire logic        core_clk,          // Core clock, 40 MHz
	input  wire logic        arst_n,            // Async reset, low active
	input  wire logic        ce,                // Freezes all state when low
	input  wire logic        xtal_tick,         // Crystal reference strobe
	input  wire logic        pll_tick,          // PLL reference strobe
	input  wire logic        ref_sel,           // 1 selects PLL reference
	input  wire logic        div_en,            // Divider enable
	input  wire logic        div_bypass,        // Divider bypass
	input  wire logic        div_update,        // Load M and N
	input  wire logic [19:0] divider_numerator,   // M value
	input  wire logic [19:0] divider_denominator, // N value
	input  wire logic        port_en,           // Port enable
	input  wire logic        clk_master,        // Port drives bit clock
	input  wire logic        frame_master,      // Port drives frame sync
	input  wire logic [3:0]  sample_size_field, // Sample size minus one, low
	input  wire logic        extended_size_bit, // Sample size minus one, top
	input  wire logic [2:0]  slot_count,        // Active slots minus one
	input  wire logic [7:0]  tx_slot_en,        // Transmit slot enables
	input  wire logic [7:0]  rx_slot_en,        // Receive slot enables
	input  wire logic        rx_wo_tx,          // Receive without transmit
	input  wire logic [3:0]  tx_thresh,         // Transmit trigger level
	input  wire logic [3:0]  rx_thresh,         // Receive trigger level
	input  wire logic        tx_service_en,     // Transmit request enable
	input  wire logic        rx_service_en,     // Receive request enable
	input  wire logic        err_clr,           // Clears error flags
	input  wire logic        win_wr,            // Window write strobe
	input  wire logic [31:0] win_wdata,         // Window write data
	input  wire logic        win_rd,            // Window read strobe
	output logic      [31:0] win_rdata,         // Window read data
	output logic             win_rvalid,        // Read data valid pulse
	input  wire logic        sclk_in,           // Bit clock pin in
	output logic             sclk_out,          // Bit clock pin out
	output logic             sclk_oe,           // Bit clock drive enable
	input  wire logic        frm_in,            // Frame sync pin in
	output logic             frm_out,           // Frame sync pin out
	output logic             frm_oe,            // Frame sync drive enable
	input  wire logic        serial_rx_line,    // Receive data pin
	output logic             serial_tx_line,    // Transmit data pin
	output logic             tx_service_req,    // Transmit refill request
	output logic             rx_service_req,    // Receive drain request
	output logic      [4:0]  tx_level,          // Transmit queue entries
	output logic      [4:0]  rx_level,          // Receive queue entries
	output logic             rx_overrun,        // Sample lost, queue full
	output logic             tx_underrun,       // Slot had no data
	output logic             mode_error,        // Frame and clock mismatch
	output logic             busy               // Serial engine active
);

	localparam logic [asp_pkg::CNT_W-1:0] FULL = asp_pkg::FULL_CNT;

	logic [31:0]             tx_mem [DEPTH];
	logic [31:0]             rx_mem [DEPTH];
	logic [asp_pkg::PTR_W-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
	logic                    tx_push, tx_pop, rx_push, rx_pop;
	logic [31:0]             rx_word;

	logic                    div_tick;
	logic                    ref_tick;
	logic [asp_pkg::SIZE_W-1:0] size_m1;
	logic [31:0]             size_mask;
	logic                    mode_ok, run_en, continuous;

	logic                    sclk_s1, sclk_s2, sclk_s3;
	logic                    frm_s1, frm_s2, frm_s3;
	logic                    rxd_s1, rxd_s2;
	logic                    primed;

	asp_pkg::asp_state_t     state;
	logic [2:0]              gap;
	logic                    toggle, start, drv, smp;
	logic [asp_pkg::SIZE_W-1:0] bit_idx;
	logic [asp_pkg::SLOT_W-1:0] slot;
	logic [31:0]             tx_sh, rx_sh, next_tx_word;
	logic                    last_bit, frame_end, frm_start;

	// ==========================================================
	// Configuration decode
	// ==========================================================
	assign size_m1 = ({extended_size_bit, sample_size_field} <
		asp_pkg::SIZE_MIN_M1) ? asp_pkg::SIZE_MIN_M1 :
		{extended_size_bit, sample_size_field}; // [RULE_10]
	assign size_mask = asp_pkg::ALL_ONES >>
		(asp_pkg::SIZE_MAX_M1 - size_m1);
	// Frame direction follows clock direction, else the port holds off
	assign mode_ok    = (clk_master == frame_master); // [RULE_03]
	assign run_en     = port_en && mode_ok;
	assign continuous = rx_wo_tx || (slot_count != '0);
	assign ref_tick   = ref_sel ? pll_tick : xtal_tick; // [RULE_02]

	// ==========================================================
	// Divider
	// ==========================================================
	asp_frac_div #(
		.NUM_W (asp_pkg::NUM_W)
	) u_div (
		.core_clk  (core_clk),
		.arst_n    (arst_n),
		.ce        (ce),
		.ref_tick  (ref_tick),
		.div_en    (div_en),
		.bypass    (div_bypass),
		.update    (div_update),
		.num_in    (divider_numerator),
		.den_in    (divider_denominator),
		.edge_tick (div_tick)
	);

	// ==========================================================
	// Pin synchronisers
	// ==========================================================
	// The third stages only hold the previous value for edge detection
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sclk_s1 <= 1'b0;
			sclk_s2 <= 1'b0;
			sclk_s3 <= 1'b0;
			frm_s1  <= 1'b0;
			frm_s2  <= 1'b0;
			frm_s3  <= 1'b0;
			rxd_s1  <= 1'b0;
			rxd_s2  <= 1'b0;
			primed  <= 1'b0;
		end else if (ce) begin // [RULE_01]
			sclk_s1 <= sclk_in;
			sclk_s2 <= sclk_s1;
			sclk_s3 <= sclk_s2;
			frm_s1  <= frm_in;
			frm_s2  <= frm_s1;
			frm_s3  <= frm_s2;
			rxd_s1  <= serial_rx_line;
			rxd_s2  <= rxd_s1;
			primed  <= 1'b1;
		end
	end

	// ==========================================================
	// Bit clock events
	// ==========================================================
	// Edges are spaced by a floor on half periods to cap the bit rate
	assign toggle = clk_master && (state != asp_pkg::ASP_IDLE) &&
		div_tick && (gap >= 3'(asp_pkg::MIN_HALF_CYC)); // [RULE_09]
	assign start = clk_master && (state == asp_pkg::ASP_IDLE) &&
		run_en && (continuous || tx_level != '0);
	// A slave edge seen before the stages are primed is dropped
	assign drv = clk_master ? ((toggle && sclk_out) || start) :
		(primed && !sclk_s2 && sclk_s3 &&
		state == asp_pkg::ASP_RUN); // [RULE_04]
	assign smp = clk_master ? (toggle && !sclk_out &&
		state == asp_pkg::ASP_RUN) :
		(primed && sclk_s2 && !sclk_s3 && state == asp_pkg::ASP_RUN);
	assign frm_start = !clk_master && frm_s2 && !frm_s3;
	assign last_bit  = (bit_idx == size_m1);
	assign frame_end = last_bit && (slot == slot_count);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			gap <= '0;
		end else if (ce) begin
			if (toggle || state == asp_pkg::ASP_IDLE)
				gap <= '0;
			else if (gap != asp_pkg::GAP_MAX)
				gap <= gap + 3'h1;
		end
	end

	// ==========================================================
	// Engine state
	// ==========================================================
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= asp_pkg::ASP_IDLE;
		end else if (ce) begin
			if (!run_en) begin // [RULE_13]
				state <= asp_pkg::ASP_IDLE;
			end else begin
				unique case (state)
				asp_pkg::ASP_IDLE: begin
					if (start || !clk_master)
						state <= asp_pkg::ASP_RUN;
				end
				asp_pkg::ASP_RUN: begin
					// Clock stops after a frame unless it must run on
					if (clk_master && smp && frame_end &&
						!continuous && tx_level == '0) // [RULE_23]
						state <= asp_pkg::ASP_STOP;
				end
				asp_pkg::ASP_STOP: begin
					if (toggle)
						state <= asp_pkg::ASP_IDLE;
				end
				endcase
			end
		end
	end

	// ==========================================================
	// Bit clock and frame sync outputs
	// ==========================================================
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			sclk_out <= 1'b0;
			sclk_oe  <= 1'b0;
			frm_out  <= 1'b0;
			frm_oe   <= 1'b0;
		end else if (ce) begin
			sclk_oe <= clk_master && run_en;
			frm_oe  <= clk_master && run_en; // [RULE_03]
			if (!run_en || !clk_master)
				sclk_out <= 1'b0;
			else if (toggle)
				sclk_out <= !sclk_out; // [RULE_23]
			if (!run_en || !clk_master)
				frm_out <= 1'b0;
			else if (drv && state != asp_pkg::ASP_STOP)
				frm_out <= (bit_idx == '0) && (slot == '0);
			else if (state == asp_pkg::ASP_IDLE)
				frm_out <= 1'b0;
		end
	end

	// ==========================================================
	// Bit and slot counters
	// ==========================================================
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			bit_idx <= '0;
			slot    <= '0;
		end else if (ce) begin
			if (state == asp_pkg::ASP_IDLE || !run_en) begin
				bit_idx <= '0;
				slot    <= '0;
			end else if (smp && frm_start) begin
				// Slave realigns: this rise carries bit 0 of slot 0
				bit_idx <= 5'h1;
				slot    <= '0;
			end else if (smp) begin
				if (last_bit) begin
					bit_idx <= '0;
					slot    <= frame_end ? '0 : slot + 3'h1; // [RULE_12]
				end else begin
					bit_idx <= bit_idx + 5'h1;
				end
			end
		end
	end

	// ==========================================================
	// Transmit serializer
	// ==========================================================
	// Word is left aligned so the top bit leaves first
	assign next_tx_word = ((tx_mem[tx_rp] & size_mask) <<
		(asp_pkg::SIZE_MAX_M1 - size_m1)); // [RULE_15] [RULE_22]
	assign tx_pop = drv && (state == asp_pkg::ASP_RUN ||
		(start && state == asp_pkg::ASP_IDLE)) && bit_idx == '0 &&
		tx_slot_en[slot] && tx_level != '0;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_sh          <= '0;
			serial_tx_line <= 1'b0;
		end else if (ce) begin
			if (!run_en || state == asp_pkg::ASP_STOP) begin
				tx_sh          <= '0;
				serial_tx_line <= 1'b0;
			end else if (drv && bit_idx == '0) begin
				if (tx_pop) begin
					serial_tx_line <= next_tx_word[31];
					tx_sh          <= next_tx_word << 1;
				end else begin
					serial_tx_line <= 1'b0;
					tx_sh          <= '0;
				end
			end else if (drv) begin // [RULE_21]
				serial_tx_line <= tx_sh[31];
				tx_sh          <= tx_sh << 1;
			end
		end
	end

	// ==========================================================
	// Receive deserializer
	// ==========================================================
	assign rx_word = {rx_sh[30:0], rxd_s2} & size_mask; // [RULE_16]
	assign rx_push = smp && last_bit && !frm_start &&
		rx_slot_en[slot] && rx_level != FULL;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_sh <= '0;
		end else if (ce) begin
			if (!run_en || (smp && (last_bit || frm_start)))
				rx_sh <= frm_start ? {31'h0, rxd_s2} : '0;
			else if (smp)
				rx_sh <= {rx_sh[30:0], rxd_s2}; // [RULE_22]
		end
	end

	// ==========================================================
	// Transmit queue
	// ==========================================================
	// A write to a full queue is dropped
	assign tx_push = win_wr && (tx_level != FULL); // [RULE_20] [RULE_14]

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_wp    <= '0;
			tx_rp    <= '0;
			tx_level <= '0;
		end else if (ce) begin // [RULE_11]
			if (tx_push) begin
				tx_mem[tx_wp] <= win_wdata;
				tx_wp         <= tx_wp + 4'h1;
			end
			if (tx_pop)
				tx_rp <= tx_rp + 4'h1;
			if (tx_push && !tx_pop)
				tx_level <= tx_level + 5'h1;
			else if (tx_pop && !tx_push)
				tx_level <= tx_level - 5'h1;
		end
	end

	// ==========================================================
	// Receive queue and data window read
	// ==========================================================
	assign rx_pop = win_rd && (rx_level != '0); // [RULE_20]

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rx_wp      <= '0;
			rx_rp      <= '0;
			rx_level   <= '0;
			win_rdata  <= '0;
			win_rvalid <= 1'b0;
		end else if (ce) begin // [RULE_11]
			if (rx_push) begin
				rx_mem[rx_wp] <= rx_word;
				rx_wp         <= rx_wp + 4'h1;
			end
			if (rx_pop)
				rx_rp <= rx_rp + 4'h1;
			if (rx_push && !rx_pop)
				rx_level <= rx_level + 5'h1;
			else if (rx_pop && !rx_push)
				rx_level <= rx_level - 5'h1;
			// An empty read answers with zero data
			win_rvalid <= win_rd;
			win_rdata  <= rx_pop ? rx_mem[rx_rp] : '0;
		end
	end

	// ==========================================================
	// Service requests and status
	// ==========================================================
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_service_req <= 1'b0;
			rx_service_req <= 1'b0;
			rx_overrun     <= 1'b0;
			tx_underrun    <= 1'b0;
			mode_error     <= 1'b0;
			busy           <= 1'b0;
		end else if (ce) begin
			tx_service_req <= tx_service_en &&
				(tx_level <= {1'b0, tx_thresh}); // [RULE_19]
			rx_service_req <= rx_service_en &&
				(rx_level > {1'b0, rx_thresh}); // [RULE_19]
			// Set beats clear when both land together
			if (smp && last_bit && !frm_start && rx_slot_en[slot] &&
				rx_level == FULL)
				rx_overrun <= 1'b1; // [RULE_25]
			else if (err_clr)
				rx_overrun <= 1'b0;
			if (drv && bit_idx == '0 && tx_slot_en[slot] &&
				tx_level == '0 && !rx_wo_tx &&
				state != asp_pkg::ASP_STOP && run_en)
				tx_underrun <= 1'b1; // [RULE_25]
			else if (err_clr)
				tx_underrun <= 1'b0;
			mode_error <= port_en && !mode_ok; // [RULE_03]
			busy       <= (state != asp_pkg::ASP_IDLE);
		end
	end

endmodule : asp_port

// ==== design/asp_pkg.sv ====
// Constants shared by the audio serial port and its fractional divider.
// Assumes one core clock of 40 MHz; all reference and bit clocks are
// presented to the port as events or pins on that clock.
package asp_pkg;

	// ==========================================================
	// Core clock and serial timing
	// ==========================================================
	localparam int CORE_CLK_KHZ   = 40000;
	localparam int CORE_PERIOD_NS = 25;
	localparam int XTAL_REF_KHZ   = 25000;
	localparam int PLL_REF_KHZ    = 19200;
	localparam int MAX_RATE_KBPS  = 12500;
	// Shortest bit clock half period, rounded up to whole core cycles
	localparam int MIN_HALF_NS    = 1000000 / MAX_RATE_KBPS / 2;
	localparam int MIN_HALF_CYC   =
		(MIN_HALF_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;

	// ==========================================================
	// Queues and samples
	// ==========================================================
	localparam int DATA_W    = 32;
	localparam int DEPTH     = 16;
	localparam int PTR_W     = 4;
	localparam int CNT_W     = 5;
	localparam int SIZE_W    = 5;
	localparam logic [SIZE_W-1:0] SIZE_MIN_M1 = 5'h03;
	localparam logic [SIZE_W-1:0] SIZE_MAX_M1 = 5'h1F;
	localparam logic [DATA_W-1:0] ALL_ONES    = 32'hFFFFFFFF;
	localparam logic [CNT_W-1:0]  FULL_CNT    = 5'h10;

	// ==========================================================
	// Network slots and divider
	// ==========================================================
	localparam int SLOTS    = 8;
	localparam int SLOT_W   = 3;
	localparam int NUM_W    = 20;
	localparam int ACC_W    = 22;
	localparam logic [2:0] GAP_MAX = 3'h7;

	typedef enum logic [1:0] {
		ASP_IDLE,
		ASP_RUN,
		ASP_STOP
	} asp_state_t;

endpackage : asp_pkg

// ==== design/asp_frac_div.sv ====
// Fractional M/N divider producing bit clock edge events.
// Assumes ref_tick is a one-cycle strobe per reference period, made on
// core_clk by the clock control unit.
`timescale 1ns/10ps
module asp_frac_div #(
	parameter int NUM_W = asp_pkg::NUM_W
) (
	input  wire logic             core_clk,   // Core clock
	input  wire logic             arst_n,     // Async reset, low active
	input  wire logic             ce,         // Clock enable
	input  wire logic             ref_tick,   // Reference period strobe
	input  wire logic             div_en,     // Divider enable
	input  wire logic             bypass,     // Pass reference through
	input  wire logic             update,     // Load new M and N
	input  wire logic [NUM_W-1:0] num_in,     // Numerator M
	input  wire logic [NUM_W-1:0] den_in,     // Denominator N
	output logic                  edge_tick   // Half period event
);

	logic [NUM_W-1:0]         num;
	logic [NUM_W-1:0]         den;
	logic [asp_pkg::ACC_W-1:0] acc;
	logic [asp_pkg::ACC_W-1:0] sum;

	// ==========================================================
	// Shadow values
	// ==========================================================
	// Only an explicit update moves new values in, so a half-written
	// pair never sets an odd frequency
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			num <= '0;
			den <= '0;
		end else if (ce && update) begin // [RULE_24] [RULE_06]
			num <= num_in;
			den <= den_in;
		end
	end

	// Twice M per step: two edges make one output period
	assign sum = acc + {1'b0, num, 1'b0};

	// ==========================================================
	// Accumulator
	// ==========================================================
	// Edge placement jitters by at most one reference period
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			acc       <= '0;
			edge_tick <= 1'b0;
		end else if (ce) begin
			if (bypass) begin // [RULE_07]
				acc       <= '0;
				edge_tick <= ref_tick;
			end else if (!div_en || den == '0) begin // [RULE_06]
				acc       <= '0;
				edge_tick <= 1'b0;
			end else if (ref_tick) begin // [RULE_05] [RULE_08]
				if (sum >= {2'b00, den}) begin
					acc       <= sum - {2'b00, den};
					edge_tick <= 1'b1;
				end else begin
					acc       <= sum;
					edge_tick <= 1'b0;
				end
			end else begin
				edge_tick <= 1'b0;
			end
		end
	end

endmodule : asp_frac_div

// ==== test/asp_port_assertions.sv ====
// Checker for the serial port, bound onto every asp_port instance.
// Assumes one core clock domain and the async active-low reset.
`timescale 1ns/10ps
module asp_port_checker #(
	parameter int DEPTH = 16
) (
	input wire logic       core_clk, arst_n, ce, win_rd, win_wr, win_rvalid,
	input wire logic       port_en, clk_master, frame_master, mode_error,
	input wire logic       sclk_oe, frm_oe, sclk_out, serial_tx_line, busy,
	input wire logic       tx_service_en, rx_service_en,
	input wire logic       tx_service_req, rx_service_req,
	input wire logic [3:0] tx_thresh, rx_thresh,
	input wire logic [4:0] tx_level, rx_level
);
	// ==========================================================
	// Checks
	// ==========================================================
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	read_answer_a: assert property (ce && win_rd |=> win_rvalid)
		else $error("read got no answer");
	answer_cause_a: assert property (win_rvalid |-> $past(win_rd))
		else $error("answer without read");
	push_count_a: assert property (ce && win_wr && !port_en &&
		tx_level < 5'h10 |=> tx_level == $past(tx_level) + 5'h01)
		else $error("push not counted");
	level_cap_a: assert property (tx_level <= DEPTH && rx_level <= DEPTH)
		else $error("queue level above depth");
	mode_flag_a: assert property (port_en && clk_master != frame_master
		|=> mode_error) else $error("mismatch not flagged");
	mode_nodrive_a: assert property (mode_error |-> !sclk_oe && !frm_oe)
		else $error("pins driven in bad mode");
	tx_request_a: assert property ((tx_service_en &&
		tx_level <= {1'b0, tx_thresh}) [*3] |-> tx_service_req)
		else $error("transmit request missing");
	rx_request_a: assert property ((!rx_service_en ||
		rx_level <= {1'b0, rx_thresh}) [*3] |-> !rx_service_req)
		else $error("receive request spurious");
	idle_quiet_a: assert property (!busy [*2] |->
		!$past(sclk_out) && !$past(serial_tx_line))
		else $error("link not quiet when idle");
	cover property (win_rd ##1 win_rvalid);
	cover property (tx_level == 5'h10);
	cover property (busy ##1 !busy);
endmodule : asp_port_checker

bind asp_port asp_port_checker #(.DEPTH(DEPTH)) u_chk (.*);

// ==== test/asp_codec_model.sv ====
// Behavioural codec as bit clock slave on the far side of the port.
// Assumes sclk and frm are port driven; both are sampled on core_clk.
`timescale 1ns/10ps
module asp_codec_model (
	input  wire logic        core_clk, // Sampling clock
	input  wire logic        sclk,     // Bit clock
	input  wire logic        frm,      // Frame sync
	input  wire logic        tx_line,  // Port transmit data
	input  wire logic [5:0]  size,     // Bits per slot
	input  wire logic [31:0] reply,    // Word sent each frame
	output logic             rx_line,  // Data toward the port
	output logic      [31:0] heard     // Bits heard this frame
);
	logic       sclk_d = 1'b0;
	logic       frm_d  = 1'b0;
	logic [5:0] left   = 6'h00;
	initial rx_line = 1'b0;
	initial heard = 32'h0;
	// Sampled edges keep clock and frame changes in one step race free
	always @(posedge core_clk) begin
		sclk_d <= sclk;
		frm_d  <= frm;
		if (frm && !frm_d) begin
			left    <= size - 6'h01;
			rx_line <= reply[size - 6'h01];
			heard   <= 32'h0;
		end else if (sclk_d && !sclk) begin
			left    <= (left != 6'h00) ? left - 6'h01 : left;
			// Out of frame the line floats, so show a changing level
			rx_line <= (left != 6'h00) ? reply[left - 6'h01] : ~rx_line;
		end else if (!sclk_d && sclk)
			heard <= {heard[30:0], tx_line};
	end
endmodule : asp_codec_model

// ==== test/tb_audio_serial_port_fractional_clock.sv ====
// Testbench for asp_port in clock master mode with a codec model.
// Assumes inputs change at falling edges of the 40 MHz core clock.
`timescale 1ns/10ps
module tb_audio_serial_port_fractional_clock;
	logic core_clk = 1'b0, arst_n = 1'b0, pll_tick = 1'b0, ref_sel = 1'b0;
	logic div_update = 1'b0, port_en = 1'b0, clk_master = 1'b1;
	logic err_clr = 1'b0, win_wr = 1'b0, win_rd = 1'b0, ce = 1'b1;
	logic xtal_tick = 1'b1, div_en = 1'b1, div_bypass = 1'b0;
	logic frame_master = 1'b1, extended_size_bit = 1'b0, rx_wo_tx = 1'b0;
	logic tx_service_en = 1'b1, rx_service_en = 1'b1;
	logic [19:0] divider_numerator = 20'h00001;
	logic [19:0] divider_denominator = 20'h00010;
	logic [3:0]  sample_size_field = 4'h7, tx_thresh = 4'h4, rx_thresh = 4'h7;
	logic [7:0]  tx_slot_en = 8'hFF, rx_slot_en = 8'hFF;
	logic [2:0]  slot_count = 3'h0;
	logic [31:0] win_wdata = 32'h0, win_rdata, heard;
	logic        win_rvalid, sclk_out, sclk_oe, frm_out, frm_oe;
	logic        serial_rx_line, serial_tx_line;
	logic        tx_service_req, rx_service_req;
	logic        rx_overrun, tx_underrun, mode_error, busy;
	logic [4:0]  tx_level, rx_level;
	int          fail_count = 0;
	int          samples_checked = 0;
	wire         sclk = sclk_oe ? sclk_out : 1'b0;
	wire         frm  = frm_oe ? frm_out : 1'b0;

	initial forever #12.5 core_clk = ~core_clk;
	always @(negedge core_clk) pll_tick <= ~pll_tick;

	// Divider M=1, N=16: a bit clock edge every 8 reference strobes
	asp_port u_dut (.*, .sclk_in(sclk), .frm_in(frm));
	asp_codec_model u_codec (.core_clk(core_clk), .sclk(sclk), .frm(frm),
		.tx_line(serial_tx_line), .size(6'h08), .reply(32'h5A5A5A3C),
		.rx_line(serial_rx_line), .heard(heard));

	// ==========================================================
	// Tasks
	// ==========================================================
	task automatic close_out;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : close_out
	task automatic check(input string what, input logic [31:0] seen, exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic bound(input int n);
		if (n >= 3000) begin
			$display("unexpected wait expired");
			fail_count++;
			close_out();
		end
	endtask : bound
	task automatic wr(input logic [31:0] d);
		@(negedge core_clk);
		win_wr = 1'b1;
		win_wdata = d;
		@(negedge core_clk);
		win_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [31:0] exp);
		@(negedge core_clk);
		win_rd = 1'b1;
		@(negedge core_clk);
		win_rd = 1'b0;
		check("win_rvalid", {31'h0, win_rvalid}, 32'h1);
		check("win_rdata", win_rdata, exp);
	endtask : rd

	// ==========================================================
	// Sequence
	// ==========================================================
	initial begin
		int n;
		repeat (16) @(negedge core_clk);
		arst_n = 1'b1;
		div_update = 1'b1;
		@(negedge core_clk);
		div_update = 1'b0;
		rd(32'h0);
		for (int i = 0; i < 17; i++) wr(32'hFFFFFFA0 | 32'(i));
		check("tx_level", {27'h0, tx_level}, 32'h10);
		check("tx_req", {31'h0, tx_service_req}, 32'h0);
		port_en = 1'b1;
		for (int j = 0; j < 16; j++) begin
			for (n = 0; n < 3000 && rx_level !== 5'(j + 1); n++) @(negedge core_clk);
			bound(n);
			repeat (2) @(negedge core_clk);
			check("heard", heard, 32'h000000A0 | 32'(j));
		end
		for (n = 0; n < 3000 && busy !== 1'b0; n++) @(negedge core_clk);
		bound(n);
		repeat (2) @(negedge core_clk);
		check("sclk_out", {31'h0, sclk_out}, 32'h0);
		check("rx_req", {31'h0, rx_service_req}, 32'h1);
		check("tx_req", {31'h0, tx_service_req}, 32'h1);
		wr(32'h000000C3);
		for (n = 0; n < 3000 && rx_overrun !== 1'b1; n++) @(negedge core_clk);
		bound(n);
		check("rx_level", {27'h0, rx_level}, 32'h10);
		for (int k = 0; k < 16; k++) rd(32'h0000003C);
		err_clr = 1'b1;
		@(negedge core_clk);
		err_clr = 1'b0;
		@(negedge core_clk);
		check("rx_overrun", {31'h0, rx_overrun}, 32'h0);
		port_en = 1'b0;
		slot_count = 3'h1;
		ref_sel = 1'b1;
		@(negedge core_clk);
		port_en = 1'b1;
		wr(32'hFFFFFF81);
		for (n = 0; n < 3000 && tx_underrun !== 1'b1; n++) @(negedge core_clk);
		bound(n);
		port_en = 1'b0;
		clk_master = 1'b0;
		@(negedge core_clk);
		port_en = 1'b1;
		repeat (2) @(negedge core_clk);
		check("mode_error", {31'h0, mode_error}, 32'h1);
		check("sclk_oe", {31'h0, sclk_oe}, 32'h0);
		close_out();
	end
endmodule : tb_audio_serial_port_fractional_clock
